//--- rtl/tmh_pkg.sv
// shared constants and types for the touch matrix host link
package tmh_pkg;
  localparam int CLK_HZ = 25000000;
  localparam int SCK_HALF = 4;
  localparam int BYTE_GAP_NS = 20000;
  localparam int BYTE_GAP_CYC = (BYTE_GAP_NS * 25 + 999) / 1000;
  localparam int POLL_MS = 50;
  localparam int POLL_CYC = POLL_MS * (CLK_HZ / 1000);
  localparam int MIN_POLL_MS = 10;
  localparam int MIN_POLL_CYC = MIN_POLL_MS * (CLK_HZ / 1000);
  localparam int UART_DIV = 217;
  localparam logic [7:0] CMD_NULL = 8'h00;
  localparam logic [7:0] CMD_LAST = 8'h0f;
  localparam logic [7:0] ACK_LAST = 8'hf0;
  localparam logic [7:0] CMD_FIRST_KEY = 8'h06;
  localparam logic [7:0] CMD_ALL_KEYS = 8'h07;
  localparam logic [7:0] CMD_ERR_A = 8'h0b;
  localparam logic [7:0] CMD_ERR_B = 8'h0c;
  localparam int FIFO_DEPTH = 8;

  typedef struct packed {
    logic [7:0] cmd;
    logic [3:0] resp_cnt;
  } tmh_req_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WAIT_RDY = 3'b001,
    ST_SHIFT = 3'b010,
    ST_GAP = 3'b011,
    ST_PUSH = 3'b100
  } tmh_state_t;
endpackage

//--- rtl/tmh_fifo.sv
// small valid/ready fifo for response bytes
`timescale 1ns/1ns
module tmh_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, rd_q;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign in_ready = (wr_q - rd_q) != (AW + 1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign out_data = mem_q[rd_q[AW-1:0]];
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
    end
  end
  always_ff @(posedge clk_sys) begin
    if (push) mem_q[wr_q[AW-1:0]] <= in_data;
  end
endmodule

//--- rtl/tmh_host.sv
// host side spi controller for the touch matrix device
// How it works
// - host uses only the spi port, rx held idle high
// - host clocks out each response byte itself
// - crc bytes pass through untouched to the user
// - host sends only while comms_ready_line is high
// - uart hold-off of comms_ready_line unused; host only reads it
// - after reset host repeats 0x0f until 0xf0 returns
// - auto poll with first-key at a 50ms period
// - null fetches follow each other as fast as the 20us gap, ready and fifo room allow
// - user picks all-keys only after first-key shows several
// - user issues error-status commands on error reports
// - after each byte wait 20us, then for ready high
// - nulls fetch all responses before the next command
// - sck idles high, shift out on fall, sample at the end of the high phase
`timescale 1ns/1ns
module tmh_host
  import tmh_pkg::*;
#(
  parameter int POLL_CYCLES = POLL_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // user command port
  input wire logic req_valid,
  input wire tmh_req_t req,
  output logic req_ready,
  input wire logic auto_poll_en,
  // user response port
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  input wire logic rsp_ready,
  output logic synced,
  // spi pins
  output logic spi_sck,
  output logic spi_mosi,
  input wire logic spi_miso,
  output logic spi_ss_n,
  // other device pins
  input wire logic comms_ready_line,
  output logic uart_rx_pin,
  output logic wake_sync_input,
  output logic sample_pin_o,
  output logic sample_pin_oe_n
);
  logic [2:0] rdy_s_q, miso_s_q;
  logic rdy_f_q, miso_f_q;
  // a pin change counts only once the last two stages agree
  wire rdy_agree = rdy_s_q[1] == rdy_s_q[2];
  wire miso_agree = miso_s_q[1] == miso_s_q[2];
  wire rdy_hi = rdy_f_q;
  wire miso_bit = miso_f_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdy_s_q <= '0;
      miso_s_q <= '0;
      rdy_f_q <= 1'b0;
      miso_f_q <= 1'b0;
    end else begin
      rdy_s_q <= {rdy_s_q[1:0], comms_ready_line};
      miso_s_q <= {miso_s_q[1:0], spi_miso};
      if (rdy_agree) rdy_f_q <= rdy_s_q[2];
      if (miso_agree) miso_f_q <= miso_s_q[2];
    end
  end

  tmh_state_t st_q, st_d;
  logic [7:0] tx_q, rx_q, cmd_q;
  logic [3:0] left_q, bit_q;
  logic [2:0] half_q;
  logic [15:0] gap_q;
  logic [31:0] poll_q;
  logic is_cmd_q, sync_q, sck_q, ss_n_q, mosi_q;
  logic fifo_in_ready, fifo_push;
  wire poll_due = poll_q == 32'h0;
  // null fetch pending has priority over any new command
  wire need_fetch = left_q != 4'h0;
  // only a request offered while ready stands is taken
  wire take_user = !need_fetch && sync_q && req_valid
    && req_ready;
  wire take_poll = !need_fetch && sync_q && !req_valid
    && auto_poll_en && poll_due;
  wire take_sync = !need_fetch && !sync_q;
  wire start = take_user || take_poll || take_sync || need_fetch;
  wire half_done = half_q == 3'(SCK_HALF - 1);

  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: if (start) st_d = ST_WAIT_RDY;
      ST_WAIT_RDY: if (rdy_hi) st_d = ST_SHIFT;
      ST_SHIFT: if (half_done && sck_q && bit_q == 4'h8)
        st_d = ST_PUSH;
      ST_PUSH: if (is_cmd_q || fifo_in_ready) st_d = ST_GAP;
      ST_GAP: if (gap_q == 16'h0 && rdy_hi) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
  end

  // response bytes only, synchronising answers stay internal
  assign fifo_push = st_q == ST_PUSH && !is_cmd_q && sync_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= ST_IDLE;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      cmd_q <= 8'h00;
      left_q <= 4'h0;
      bit_q <= 4'h0;
      half_q <= 3'h0;
      gap_q <= 16'h0;
      poll_q <= 32'h0;
      is_cmd_q <= 1'b0;
      sync_q <= 1'b0;
      sck_q <= 1'b1;
      ss_n_q <= 1'b1;
      mosi_q <= 1'b1;
    end else begin
      st_q <= st_d;
      if (st_q != ST_IDLE && poll_due) poll_q <= poll_q;
      else if (poll_due && take_poll) poll_q <= 32'(POLL_CYCLES);
      else if (!poll_due) poll_q <= poll_q - 32'h1;
      if (st_q == ST_IDLE && start) begin
        is_cmd_q <= !need_fetch;
        if (need_fetch) tx_q <= CMD_NULL;
        else if (take_user) tx_q <= req.cmd;
        else if (take_poll) tx_q <= CMD_FIRST_KEY;
        else tx_q <= CMD_LAST;
        if (take_user) left_q <= req.resp_cnt;
        else if (take_poll) left_q <= 4'h1;
        else if (take_sync) left_q <= 4'h1;
        else left_q <= left_q - 4'h1;
        if (!need_fetch) cmd_q <= take_user ? req.cmd
          : (take_poll ? CMD_FIRST_KEY : CMD_LAST);
      end
      if (st_q == ST_WAIT_RDY && rdy_hi) begin
        ss_n_q <= 1'b0;
        bit_q <= 4'h0;
        half_q <= 3'h0;
        mosi_q <= tx_q[7];
      end
      if (st_q == ST_SHIFT) begin
        half_q <= half_done ? 3'h0 : half_q + 3'h1;
        if (half_done) begin
          if (sck_q) begin
            // sample at the end of the high phase: the synchroniser
            // delay would put a sample at the rise on the old bit
            if (bit_q != 4'h0) rx_q <= {rx_q[6:0], miso_bit};
            if (bit_q != 4'h0 && bit_q != 4'h8)
              mosi_q <= tx_q[3'h7 - bit_q[2:0]];
            if (bit_q != 4'h8) sck_q <= 1'b0;
          end else begin
            sck_q <= 1'b1;
            bit_q <= bit_q + 4'h1;
          end
        end
      end
      if (st_q == ST_PUSH && st_d == ST_GAP) begin
        ss_n_q <= 1'b1;
        mosi_q <= 1'b1;
        gap_q <= 16'(BYTE_GAP_CYC);
        // ack of 0x0f ends the resync loop
        if (!sync_q && !is_cmd_q && cmd_q == CMD_LAST
          && rx_q == ACK_LAST) sync_q <= 1'b1;
      end
      if (st_q == ST_GAP && gap_q != 16'h0) gap_q <= gap_q - 16'h1;
    end
  end

  logic [7:0] rsp_d_w;
  logic rsp_v_w;
  wire rsp_take = !rsp_valid || rsp_ready;
  wire rsp_load = rsp_v_w && rsp_take;
  tmh_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .rst(rst),
    .in_valid(fifo_push),
    .in_data(rx_q),
    .in_ready(fifo_in_ready),
    .out_valid(rsp_v_w),
    .out_data(rsp_d_w),
    .out_ready(rsp_take)
  );

  // output stage registers so each port comes from a flop
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
      req_ready <= 1'b0;
      synced <= 1'b0;
    end else begin
      // refill as a byte leaves, so bursts drain at full rate
      if (rsp_load) begin
        rsp_valid <= 1'b1;
        rsp_data <= rsp_d_w;
      end else if (rsp_ready) begin
        rsp_valid <= 1'b0;
      end
      req_ready <= st_d == ST_IDLE && st_q == ST_IDLE && !need_fetch
        && sync_q && !take_user;
      synced <= sync_q;
    end
  end

  // idle levels keep the device in spi mode with defaults kept
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      spi_sck <= 1'b1;
      spi_mosi <= 1'b1;
      spi_ss_n <= 1'b1;
      uart_rx_pin <= 1'b1;
      wake_sync_input <= 1'b1;
      sample_pin_o <= 1'b0;
      sample_pin_oe_n <= 1'b0;
    end else begin
      spi_sck <= sck_q;
      spi_mosi <= mosi_q;
      spi_ss_n <= ss_n_q;
      uart_rx_pin <= 1'b1;
      wake_sync_input <= 1'b1;
      sample_pin_o <= 1'b0;
      sample_pin_oe_n <= 1'b0;
    end
  end
endmodule

//--- dv/tmh_host_assertions.sv
// pin-level assertions for the touch matrix host link
`timescale 1ns/1ns
module tmh_host_assertions
  import tmh_pkg::*;
(
  // clock, reset, user side
  input wire logic clk_sys, rst, req_ready, rsp_valid, rsp_ready, synced,
  input wire logic [7:0] rsp_data,
  // device pins
  input wire logic spi_sck, spi_mosi, spi_ss_n, comms_ready_line,
  input wire logic uart_rx_pin, wake_sync_input, sample_pin_o, sample_pin_oe_n
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  int gap_q;
  // starts full so the first frame after reset is not flagged
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) gap_q <= BYTE_GAP_CYC;
    else gap_q <= !spi_ss_n ? 0 : gap_q + int'(gap_q < BYTE_GAP_CYC);
  end
  a_sck_idle: assert property (spi_ss_n |-> spi_sck)
    else $error("sck low outside frame");
  a_sck_half: assert property (
    $changed(spi_sck) |=> $stable(spi_sck)[*3]) else $error("sck too fast");
  a_mosi_rise: assert property (
    $rose(spi_sck) && !spi_ss_n |-> $stable(spi_mosi)) else $error("mosi");
  a_send_ready: assert property (
    $fell(spi_ss_n) |-> $past(comms_ready_line, 2)) else $error("not ready");
  a_byte_gap: assert property (
    $fell(spi_ss_n) |-> gap_q >= BYTE_GAP_CYC) else $error("gap short");
  a_pins_park: assert property (
    uart_rx_pin && wake_sync_input && !sample_pin_o && !sample_pin_oe_n)
    else $error("pins moved");
  a_rsp_hold: assert property (
    rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
    else $error("rsp dropped");
  a_sync_gate: assert property (!synced |-> !rsp_valid && !req_ready)
    else $error("traffic before sync");
  a_sync_stick: assert property (synced |=> synced)
    else $error("sync lost");
  c_sync: cover property ($rose(synced));
  c_take: cover property (rsp_valid && rsp_ready);
  c_frame: cover property ($fell(spi_ss_n));
endmodule

//--- dv/tmh_dev_model.sv
// behavioural spi slave standing in for the touch matrix device
`timescale 1ns/1ns
module tmh_dev_model (
  // host pins
  input wire logic spi_sck, spi_mosi, spi_ss_n,
  // long busy time when high
  input wire logic slow,
  output logic spi_miso, comms_ready_line
);
  logic [7:0] rx_q = 8'h00, tx_q = 8'h00, sh_q = 8'h00;
  logic bit_q = 1'b0;
  int pend = 0;
  // deselected miso floats: show the inverse so nothing stale passes
  assign spi_miso = spi_ss_n ? ~bit_q : bit_q;
  initial begin
    comms_ready_line = 1'b0;
    #5000 comms_ready_line = 1'b1;
  end
  always @(negedge spi_ss_n) sh_q = tx_q;
  always @(negedge spi_sck) if (!spi_ss_n) begin
    bit_q = sh_q[7];
    sh_q = {sh_q[6:0], 1'b0};
  end
  always @(posedge spi_sck) if (!spi_ss_n) rx_q = {rx_q[6:0], spi_mosi};
  always @(posedge spi_ss_n) begin
    comms_ready_line = 1'b0;
    if (pend > 0) begin
      pend--;
      tx_q = pend > 0 ? tx_q + 8'h01 : 8'h00;
    end else if (rx_q != 8'h00) begin
      tx_q = rx_q == 8'h0f ? ~rx_q : {4'ha, rx_q[3:0]};
      pend = rx_q == 8'h07 ? 3 : rx_q == 8'h0d ? 10 : 1;
    end
    #(slow ? 30000 : 3000) comms_ready_line = 1'b1;
  end
endmodule

//--- dv/touch_matrix_host_serial_link_tb.sv
// self-checking bench for the touch matrix host link
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module touch_matrix_host_serial_link_tb import tmh_pkg::*; ;
  logic clk_sys = 0, rst = 1, req_valid = 0, auto_poll_en = 0, rsp_ready = 0;
  logic slow = 0, req_ready, rsp_valid, synced, spi_sck, spi_mosi, spi_miso;
  logic spi_ss_n, comms_ready_line, uart_rx_pin, wake_sync_input;
  logic sample_pin_o, sample_pin_oe_n;
  logic [7:0] rsp_data;
  tmh_req_t req = '0;
  int n_mismatch = 0, num_checks = 0, cyc = 0;
  typedef struct { logic [7:0] cmd; logic [3:0] cnt; } tmh_row_t;
  tmh_row_t rows [4] = '{'{8'h06, 4'h1}, '{8'h07, 4'h3}, '{8'h0b, 4'h1},
    '{8'h0c, 4'h1}};
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (++cyc == 80000) begin
    n_mismatch++;
    stop_test();
  end
  tmh_host #(.POLL_CYCLES(2000)) i_dut (.clk_sys, .rst, .req_valid, .req,
    .req_ready, .auto_poll_en, .rsp_valid, .rsp_data, .rsp_ready, .synced,
    .spi_sck, .spi_mosi, .spi_miso, .spi_ss_n, .comms_ready_line,
    .uart_rx_pin, .wake_sync_input, .sample_pin_o, .sample_pin_oe_n);
  tmh_dev_model i_dev (.spi_sck, .spi_mosi, .spi_ss_n, .slow, .spi_miso,
    .comms_ready_line);
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wait_sync();
    repeat (20000) if (synced !== 1'b1) @(negedge clk_sys);
    `CHK(synced, 1'b1)
  endtask
  // command stays offered until the host shows it can take it
  task automatic send(logic [7:0] c, logic [3:0] n);
    @(negedge clk_sys);
    req = '{c, n};
    req_valid = 1;
    // ready seen high off the edge: the next rising edge takes it
    while (req_ready !== 1'b1) @(negedge clk_sys);
    @(negedge clk_sys);
    req_valid = 0;
  endtask
  task automatic collect(logic [7:0] first, int n, int hold);
    for (int i = 0; i < n; i++) begin
      while (rsp_valid !== 1'b1) @(negedge clk_sys);
      repeat (hold) @(negedge clk_sys);
      `CHK(rsp_data, first + 8'(i))
      rsp_ready = 1;
      @(negedge clk_sys);
      rsp_ready = 0;
      @(negedge clk_sys);
    end
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    `CHK({synced, rsp_valid, spi_ss_n, spi_sck}, 4'h3)
    `CHK({uart_rx_pin, sample_pin_o, sample_pin_oe_n}, 3'h4)
    rst = 0;
    wait_sync();
    $display("resync done");
    foreach (rows[k]) begin
      send(rows[k].cmd, rows[k].cnt);
      collect({4'ha, rows[k].cmd[3:0]}, rows[k].cnt, 0);
      $display("command %h done", rows[k].cmd);
    end
    // fifo fills while the user stalls, then drains in order
    send(8'h0d, 10);
    repeat (9000) @(negedge clk_sys);
    collect(8'had, 10, 3);
    $display("burst done");
    slow = 1;
    send(8'h06, 1);
    collect(8'ha6, 1, 0);
    slow = 0;
    $display("slow device done");
    auto_poll_en = 1;
    collect(8'ha6, 1, 0);
    auto_poll_en = 0;
    $display("poll done");
    // reset in mid burst leaves the device out of step
    send(8'h0d, 10);
    collect(8'had, 2, 0);
    rst = 1;
    @(negedge clk_sys);
    `CHK({synced, rsp_valid, spi_ss_n}, 3'h1)
    rst = 0;
    wait_sync();
    send(8'h07, 3);
    collect(8'ha7, 3, 0);
    $display("resync after loss done");
    stop_test();
  end
endmodule
bind tmh_host tmh_host_assertions i_chk (.clk_sys, .rst, .req_ready,
  .rsp_valid, .rsp_ready, .synced, .rsp_data, .spi_sck, .spi_mosi, .spi_ss_n,
  .comms_ready_line, .uart_rx_pin, .wake_sync_input, .sample_pin_o,
  .sample_pin_oe_n);
